// File: hw/pin_mux_cfg.svh
// constants for the port pin override and sleep clamp block
// Behaviour
// - sleep clamps digital input to ground
// - enabled external interrupt pins bypass clamp
// - clamp-made edge sets flag on wake
// - pull-up follows override, else dir/out/pud 010
// - pull-up override ignores port bits entirely
// - driver enable from override or direction bit
// - direction override value sets driver on/off
// - driven level from override or output bit
// - value override forces port value
// - toggle override inverts output register bit
// - input enable from override or sleep state
// - input enable override ignores sleep state
// - alt input taken before port synchronizer
// - analog path goes straight to pad
// - strobes per port, sleep/pud shared, overrides per pin
// - pull-ups off while reset active
// - direction bit one output, zero input
// - pull-up disable bit 4 kills all pull-ups not under override
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define PM_PINS 8
`define PM_REG_PORT_OUT 32'h0000_0000
`define PM_REG_PORT_DIR 32'h0000_0004
`define PM_REG_PORT_PIN 32'h0000_0008
`define PM_REG_MCU_CTRL 32'h0000_000c
`define PM_REG_SLEEP 32'h0000_0010
`define PM_REG_EXT_IRQ 32'h0000_0014
`define PM_PUD_BIT 4
`define PM_RESET_VAL 8'h00
`endif

// File: hw/pin_mux_pkg.sv
// types for the port pin override block
package pin_mux_pkg;
  typedef struct packed {
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] dir_override_en;
    logic [7:0] dir_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] toggle_override_en;
    logic [7:0] input_enable_override_en;
    logic [7:0] input_enable_override_val;
  } override_s;
  typedef struct packed {
    logic [7:0] pullup_on;
    logic [7:0] drive_en_n;
    logic [7:0] drive_val;
    logic [7:0] input_en;
  } pad_ctrl_s;
  typedef enum logic [1:0] {RESP_IDLE, RESP_BUSY} resp_e;
endpackage

// File: hw/pin_sync3.sv
// three stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_s;
  sync_state_s st;
  sync_state_s next_st;
  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end
  // s1 feeds only s2; the filtered value moves when s2 and s3 agree
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.q;
endmodule // pin_sync3

// File: hw/port_pin_override_and_sleep_clamp.sv
// one port of override pin logic with sleep clamp and axi4-lite registers
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
module port_pin_override_and_sleep_clamp (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // per pin overrides from peripherals
  input wire pin_mux_pkg::override_s ovr,
  // pad side
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output logic [7:0] pad_pullup,
  output logic [7:0] alt_function_input,
  output logic [7:0] ext_irq_flag
);
  // analog_pad_io is a pad-level wire routed around this block
  typedef struct packed {
    logic [7:0] pin_output_bit;
    logic [7:0] pin_direction_bit;
    logic global_pullup_disable;
    logic sleep_qual;
    logic [7:0] ext_irq_en;
    logic [7:0] ext_irq_edge;
    logic [7:0] ext_irq_flag;
    logic [7:0] prev_in;
    logic aw_hold;
    logic [31:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } port_state_s;
  port_state_s st;
  port_state_s next_st;
  pin_mux_pkg::pad_ctrl_s pad;
  logic [7:0] clamped_in;
  logic [7:0] sync_in;
  logic [7:0] pull_req;
  logic [7:0] out_eff;

  // output bit as seen through the toggle override
  assign out_eff = st.pin_output_bit ^ ovr.toggle_override_en;

  // pad control is combinational so overrides reach the pad at once
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pull_req[i] = !st.pin_direction_bit[i] && out_eff[i] &&
                    !st.global_pullup_disable;
      pad.pullup_on[i] = ovr.pullup_override_en[i] ?
                         ovr.pullup_override_val[i] : pull_req[i];
      // direction bit one drives, zero listens
      pad.drive_en_n[i] = ovr.dir_override_en[i] ?
                          !ovr.dir_override_val[i] :
                          !st.pin_direction_bit[i];
      pad.drive_val[i] = ovr.value_override_en[i] ?
                         ovr.value_override_val[i] : out_eff[i];
      // external interrupt pins keep listening in sleep
      pad.input_en[i] = ovr.input_enable_override_en[i] ?
                        ovr.input_enable_override_val[i] :
                        (!st.sleep_qual || st.ext_irq_en[i]);
    end
  end

  // clamp ahead of the schmitt stage when input disabled
  assign clamped_in = pad_in & pad.input_en;
  // alt function sees the raw value; consumer synchronises it
  assign alt_function_input = clamped_in;
  // pull-ups held off in reset so a floating board sees no current
  assign pad_pullup = aresetn ? pad.pullup_on : 8'h00;
  assign pad_oe_n = aresetn ? pad.drive_en_n : 8'hff;
  assign pad_out = pad.drive_val;
  assign ext_irq_flag = st.ext_irq_flag;

  pin_sync3 #(.WIDTH(`PM_PINS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(clamped_in),
    .sync_out(sync_in)
  );

  // axi handshakes: accept address/data when not holding a response;
  // one register set and strobe path serves all eight pins
  assign s_axi_awready = !st.aw_hold && !st.bvalid;
  assign s_axi_wready = !st.w_hold && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  // next state: bus writes, reads, edge capture; hardware set beats clear
  always_comb begin
    logic [7:0] edge_hit;
    logic [7:0] wb;
    logic do_wr;
    next_st = st;
    edge_hit = 8'h00;
    wb = 8'h00;
    do_wr = 1'b0;
    next_st.prev_in = sync_in;
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_hold && st.w_hold) begin
      do_wr = 1'b1;
      wb = st.w_strb[0] ? st.w_data[7:0] : 8'h00;
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      case (st.aw_addr)
        `PM_REG_PORT_OUT: begin
          if (st.w_strb[0]) next_st.pin_output_bit = wb;
        end
        `PM_REG_PORT_DIR: begin
          if (st.w_strb[0]) next_st.pin_direction_bit = wb;
        end
        `PM_REG_PORT_PIN: begin
          next_st.pin_output_bit = st.pin_output_bit ^ wb; // toggle
        end
        `PM_REG_MCU_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.global_pullup_disable = wb[`PM_PUD_BIT];
          end
        end
        `PM_REG_SLEEP: begin
          if (st.w_strb[0]) next_st.sleep_qual = wb[0];
        end
        `PM_REG_EXT_IRQ: begin
          if (st.w_strb[0]) next_st.ext_irq_en = wb;
          if (st.w_strb[1]) next_st.ext_irq_edge = st.w_data[15:8];
          // write one clears flags
          if (st.w_strb[2]) begin
            next_st.ext_irq_flag = st.ext_irq_flag & ~st.w_data[23:16];
          end
        end
        default: next_st.bresp = 2'b10;
      endcase
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      case (s_axi_araddr)
        `PM_REG_PORT_OUT: next_st.rdata = {24'h0000_00, st.pin_output_bit};
        `PM_REG_PORT_DIR: next_st.rdata = {24'h0000_00, st.pin_direction_bit};
        `PM_REG_PORT_PIN: next_st.rdata = {24'h0000_00, sync_in};
        `PM_REG_MCU_CTRL: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rdata[`PM_PUD_BIT] = st.global_pullup_disable;
        end
        `PM_REG_SLEEP: next_st.rdata = {31'h0000_0000, st.sleep_qual};
        `PM_REG_EXT_IRQ: begin
          next_st.rdata = {8'h00, st.ext_irq_flag, st.ext_irq_edge,
                           st.ext_irq_en};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'b10;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // edge mode pins flag on any change, including the clamp release on
    // wake, even while their interrupt is masked
    edge_hit = st.ext_irq_edge & (sync_in ^ st.prev_in);
    next_st.ext_irq_flag = next_st.ext_irq_flag | edge_hit;
    if (do_wr) begin
      next_st.w_strb = st.w_strb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // pull-up never on while reset is low
  a_reset_pullup: assert property (@(posedge aclk)
    !aresetn |-> pad_pullup == 8'h00)
    else $error("pull-up active in reset");
  // pull-up override decides alone
  a_pullup_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr.pullup_override_en[0] |->
      pad_pullup[0] == ovr.pullup_override_val[0])
    else $error("pull-up override ignored");
  // default pull-up only for input, output one, no disable
  a_pullup_dflt: assert property (@(posedge aclk) disable iff (!aresetn)
    !ovr.pullup_override_en[1] |-> pad_pullup[1] ==
      (!st.pin_direction_bit[1] && out_eff[1] &&
       !st.global_pullup_disable))
    else $error("default pull-up wrong");
  // driver enable follows override or direction
  a_dir_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_oe_n[2] == (ovr.dir_override_en[2] ? !ovr.dir_override_val[2]
                    : !st.pin_direction_bit[2]))
    else $error("driver enable wrong");
  // driven value follows override
  a_value_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr.value_override_en[3] |-> pad_out[3] == ovr.value_override_val[3])
    else $error("value override ignored");
  // sleeping pin without override or irq reads zero
  a_sleep_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.sleep_qual && !st.ext_irq_en[4] &&
     !ovr.input_enable_override_en[4]) |-> alt_function_input[4] == 1'b0)
    else $error("input not clamped in sleep");
  // interrupt pin bypasses clamp
  a_irq_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.ext_irq_en[5] && !ovr.input_enable_override_en[5]) |->
      alt_function_input[5] == pad_in[5])
    else $error("irq pin clamped");
  // input enable override wins over sleep
  a_ie_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr.input_enable_override_en[6] |->
      alt_function_input[6] == (pad_in[6] & ovr.input_enable_override_val[6]))
    else $error("input override ignored");
  // synced change on an edge pin raises its flag next cycle
  a_edge_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.ext_irq_edge[7] && sync_in[7] != st.prev_in[7]) |=>
      ext_irq_flag[7])
    else $error("edge flag missed");
endmodule // port_pin_override_and_sleep_clamp

// File: sim/periph_model.sv
// peripheral model that drives the per pin override signals
`timescale 1ns/1ps
module periph_model (
  input wire logic aclk,
  input wire logic slow,
  input wire pin_mux_pkg::override_s req,
  output pin_mux_pkg::override_s ovr
);
  pin_mux_pkg::override_s stage;
  // overrides leave a peripheral register, after one or two stages
  // no reset: a peripheral may hold overrides while the port is in reset
  always_ff @(posedge aclk) begin
    stage <= req;
    ovr <= slow ? stage : req;
  end
endmodule // periph_model

// File: sim/tb_top.sv
// testbench for the port pin override and sleep clamp block
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup, alt_in, flag;
  pin_mux_pkg::override_s req, ovr, o;
  int n_fail = 0;
  int samples_checked = 0;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  periph_model peri (.aclk(aclk), .slow(slow), .req(req), .ovr(ovr));

  port_pin_override_and_sleep_clamp dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ovr(ovr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
    .alt_function_input(alt_in), .ext_irq_flag(flag)
  );

  // single exit point, also taken when a wait runs out
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_pad(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bus(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic guard(input int n);
    if (n > 200) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // readies are sampled mid-cycle so the edge that takes them is known
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic ta, tw;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      guard(n++);
    end while ((awvalid && !ta) || (wvalid && !tw));
    do begin
      @(negedge aclk);
      guard(n++);
    end while (bvalid !== 1'b1);
    chk_bus("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      guard(n++);
    end while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      guard(n++);
    end while (rvalid !== 1'b1);
    chk_bus("rdata", e, rdata);
    chk_bus("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // synchroniser and peripheral stages need a few edges to settle
  task automatic set_ovr(input pin_mux_pkg::override_s v);
    @(posedge aclk);
    req <= v;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    pad_in = 8'h00;
    o = '0;
    req = '0;
    req.pullup_override_en = 8'hff;
    req.pullup_override_val = 8'hff;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk_pad("pullup in reset", 8'h00, pad_pullup);
    chk_pad("oe_n in reset", 8'hff, pad_oe_n);
    @(posedge aclk);
    aresetn <= 1'b1;
    req <= '0;
    wr(`PM_REG_PORT_OUT, 32'h0000_00a5, 2'b00);
    wr(`PM_REG_PORT_DIR, 32'h0000_000f, 2'b00);
    rd_chk(`PM_REG_PORT_OUT, 32'h0000_00a5, 2'b00);
    chk_pad("oe_n", 8'hf0, pad_oe_n);
    chk_pad("pad_out", 8'h05, pad_out & 8'h0f);
    chk_pad("pullup", 8'ha0, pad_pullup);
    wr(`PM_REG_MCU_CTRL, 32'h0000_0010, 2'b00);
    chk_pad("pullup pud", 8'h00, pad_pullup);
    rd_chk(`PM_REG_MCU_CTRL, 32'h0000_0010, 2'b00);
    // a write with no byte enabled must leave the register alone
    wstrb <= 4'h0;
    wr(`PM_REG_PORT_OUT, 32'h0000_0000, 2'b00);
    wstrb <= 4'hf;
    rd_chk(`PM_REG_PORT_OUT, 32'h0000_00a5, 2'b00);
    // one override set covers all three pad output paths, slow peripheral
    o.pullup_override_en = 8'hff;
    o.pullup_override_val = 8'h3c;
    o.dir_override_en = 8'hf0;
    o.dir_override_val = 8'h30;
    o.value_override_en = 8'h03;
    o.value_override_val = 8'h02;
    o.toggle_override_en = 8'h0c;
    slow <= 1'b1;
    set_ovr(o);
    chk_pad("pullup ovr", 8'h3c, pad_pullup);
    chk_pad("oe_n ovr", 8'hc0, pad_oe_n);
    chk_pad("pad_out ovr", 8'h2a, pad_out & 8'h3f);
    wr(32'h0000_0040, 32'h0000_0001, 2'b10);
    rd_chk(32'h0000_0040, 32'h0000_0000, 2'b10);
    set_ovr('0);
    @(posedge aclk);
    pad_in <= 8'h5a;
    @(negedge aclk);
    chk_pad("alt input", 8'h5a, alt_in);
    repeat (6) @(posedge aclk);
    rd_chk(`PM_REG_PORT_PIN, 32'h0000_005a, 2'b00);
    wr(`PM_REG_EXT_IRQ, 32'h0000_0003, 2'b00);
    wr(`PM_REG_SLEEP, 32'h0000_0001, 2'b00);
    pad_in <= 8'hff;
    set_ovr('0);
    chk_pad("alt sleep", 8'h03, alt_in);
    o = '0;
    o.input_enable_override_en = 8'hf0;
    o.input_enable_override_val = 8'h30;
    set_ovr(o);
    chk_pad("alt ie ovr", 8'h33, alt_in);
    wr(`PM_REG_SLEEP, 32'h0000_0000, 2'b00);
    chk_pad("alt awake", 8'h3f, alt_in);
    set_ovr('0);
    // clamp release on wake must look like a rising edge
    wr(`PM_REG_EXT_IRQ, 32'h0000_f000, 2'b00);
    wr(`PM_REG_EXT_IRQ, 32'h00ff_f000, 2'b00);
    wr(`PM_REG_SLEEP, 32'h0000_0001, 2'b00);
    set_ovr('0);
    wr(`PM_REG_EXT_IRQ, 32'h00ff_f000, 2'b00);
    chk_pad("flag asleep", 8'h00, flag);
    wr(`PM_REG_SLEEP, 32'h0000_0000, 2'b00);
    set_ovr('0);
    chk_pad("flag wake", 8'hf0, flag);
    print_verdict();
  end
endmodule // tb_top
